// ---- bench/uaf_shifter_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module uaf_shifter_model (
    // Clock
    input wire logic clk_sys,
    // Character stream from the buffer
    input wire logic tx_char_valid,
    input wire logic [7:0] tx_char_data,
    output logic tx_char_ready,
    // Stall control
    input wire logic stall
);
    logic [7:0] got [16];
    int cnt = 0;

    // A stalled shifter takes nothing
    assign tx_char_ready = !stall;

    always @(posedge clk_sys) begin
        if (tx_char_valid && tx_char_ready && cnt < 16) begin
            got[cnt] <= tx_char_data;
            cnt <= cnt + 1;
        end
    end
endmodule : uaf_shifter_model

`default_nettype wire

// ---- bench/uart_fifo_control_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "uaf_fifo_consts.svh"

module uart_fifo_control_bench;
    import uaf_pkg::*;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic rx_char_valid = 1'b0;
    logic [7:0] rx_char_data = 8'h00;
    logic stall = 1'b1;
    logic hreadyout, hresp, tx_char_valid, tx_char_ready;
    logic rx_trigger, tx_trigger, dma_mode;
    logic [31:0] hrdata, rd;
    logic [7:0] tx_char_data;
    uaf_status_t status;
    int num_errors = 0;
    int tests_run = 0;
    int lv [4] = '{8, 16, 56, 60};
    int tl [4] = '{8, 16, 32, 56};

    uaf_fifo_ctrl i_uaf_fifo_ctrl (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rx_char_valid(rx_char_valid),
        .rx_char_data(rx_char_data), .tx_char_valid(tx_char_valid),
        .tx_char_data(tx_char_data), .tx_char_ready(tx_char_ready),
        .status(status), .rx_trigger(rx_trigger), .tx_trigger(tx_trigger),
        .dma_mode(dma_mode)
    );

    uaf_shifter_model i_uaf_shifter_model (
        .clk_sys(clk_sys), .tx_char_valid(tx_char_valid),
        .tx_char_data(tx_char_data), .tx_char_ready(tx_char_ready),
        .stall(stall)
    );

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            num_errors++;
            wrap_up();
        end
    endtask : wait_rdy

    // Single word transfer; read data lands in rd
    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : bus

    // One received character as a one-cycle pulse
    task automatic push(input logic [7:0] d);
        rx_char_valid <= 1'b1;
        rx_char_data <= d;
        @(posedge clk_sys);
        rx_char_valid <= 1'b0;
        @(posedge clk_sys);
    endtask : push

    task automatic stat;
        bus(`UAF_OFS_STATUS, 1'b0, 32'h0);
    endtask : stat

    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check({rx_trigger, tx_trigger, dma_mode, tx_char_valid}, 4'h0);
        check({hresp, hreadyout}, 2'h1);
        stat();
        check(rd, 32'h0);
        $display("Reset test done");

        bus(`UAF_OFS_FIFO_CONTROL, 1'b1, 32'h09);
        #1 check({dma_mode, status.dma_mode, status.fifo_enable}, 3'h7);
        bus(`UAF_OFS_FIFO_CONTROL, 1'b0, 32'h0);
        check(rd, 32'h0);
        bus(`UAF_OFS_FIFO_CONTROL, 1'b1, 32'h00);
        #1 check({dma_mode, status.fifo_enable}, 2'h0);
        ce <= 1'b0;
        bus(`UAF_OFS_FIFO_CONTROL, 1'b1, 32'h09);
        ce <= 1'b1;
        #1 check({dma_mode, status.fifo_enable}, 2'h0);
        bus(32'h14, 1'b0, 32'h0);
        check(rd, 32'h0);
        $display("Control test done");

        push(8'h5A);
        push(8'hC3);
        stat();
        check(rd[6:0], 7'h01);
        bus(`UAF_OFS_RX_HOLDING, 1'b0, 32'h0);
        check(rd[7:0], 8'hC3);
        $display("Disabled receive test done");

        for (int k = 0; k < 4; k++) begin
            bus(`UAF_OFS_FIFO_CONTROL, 1'b1, 32'(k << 6) | 32'h03);
            @(posedge clk_sys);
            stat();
            check(rd[6:0], 7'h00);
            repeat (lv[k] - 1) push(8'h30);
            #1 check(rx_trigger, 1'b0);
            push(8'h31);
            #1 check(rx_trigger, 1'b1);
        end
        repeat (6) push(8'h32);
        stat();
        check(rd[6:0], 7'h40);
        $display("Receive trigger test done");

        bus(`UAF_OFS_FIFO_CONTROL, 1'b1, 32'h35);
        for (int i = 0; i < 12; i++) begin
            bus(`UAF_OFS_TX_HOLDING, 1'b1, 32'hA0 + 32'(i));
        end
        stat();
        check(rd[14:8], 7'h0A);
        check(tx_trigger, 1'b1);
        check({tx_char_valid, tx_char_data}, 9'h1A0);
        bus(`UAF_OFS_ENH_FEATURE, 1'b1, 32'h10);
        for (int k = 0; k < 4; k++) begin
            bus(`UAF_OFS_FIFO_CONTROL, 1'b1, 32'(k << 4) | 32'h01);
            stat();
            check(tx_trigger, (64 - 10) >= tl[k]);
        end
        $display("Transmit trigger test done");

        bus(`UAF_OFS_FIFO_CONTROL, 1'b1, 32'h05);
        @(posedge clk_sys);
        #1 check({status.tx_count, tx_char_valid}, 8'h00);
        check(status.rx_count, 7'h40);
        @(posedge clk_sys);
        #1 check(status.tx_count, 7'h00);
        @(posedge clk_sys);
        stall <= 1'b0;
        for (int i = 1; i < 4; i++) begin
            bus(`UAF_OFS_TX_HOLDING, 1'b1, 32'h50 + 32'(i));
        end
        for (int n = 0; n < 30 && i_uaf_shifter_model.cnt < 3; n++) begin
            @(posedge clk_sys);
        end
        check(32'(i_uaf_shifter_model.cnt), 32'h3);
        for (int i = 0; i < 3; i++) begin
            check(i_uaf_shifter_model.got[i], 8'h51 + 8'(i));
        end
        $display("Transmit reset test done");
        wrap_up();
    end
endmodule : uart_fifo_control_bench

`default_nettype wire

// ---- logic/uaf_fifo_consts.svh ----
`ifndef UAF_FIFO_CONSTS_SVH
`define UAF_FIFO_CONSTS_SVH

// Register byte offsets
`define UAF_OFS_FIFO_CONTROL 8'h00
`define UAF_OFS_ENH_FEATURE 8'h04
`define UAF_OFS_TX_HOLDING 8'h08
`define UAF_OFS_RX_HOLDING 8'h0C
`define UAF_OFS_STATUS 8'h10

// Field positions and reset values
`define UAF_EFE_BIT 4
`define UAF_FIFO_CTRL_RESET 8'h00
`define UAF_ENH_RESET 8'h00

// FIFO depth and trigger levels
`define UAF_DEPTH 7'h40
`define UAF_RX_LVL0 7'h08
`define UAF_RX_LVL1 7'h10
`define UAF_RX_LVL2 7'h38
`define UAF_RX_LVL3 7'h3C
`define UAF_TX_LVL0 7'h08
`define UAF_TX_LVL1 7'h10
`define UAF_TX_LVL2 7'h20
`define UAF_TX_LVL3 7'h38

`endif

// ---- logic/uaf_fifo_ctrl.sv ----
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uaf_fifo_consts.svh"

module uaf_fifo_ctrl (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Receive shifter side
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char_data,
    // Transmit shifter side
    output logic tx_char_valid,
    output logic [7:0] tx_char_data,
    input wire logic tx_char_ready,
    // Trigger and DMA mode outputs
    output uaf_pkg::uaf_status_t status,
    output logic rx_trigger,
    output logic tx_trigger,
    output logic dma_mode
);
    import uaf_pkg::*;

    uaf_fifo_control_t fifo_control;
    logic enhanced_functions_enable;
    uaf_reg_sel_t dp_sel;
    logic dp_write;
    uaf_reg_sel_t next_sel;
    logic ap_valid;
    logic [7:0] rx_holding_fifo [64];
    logic [7:0] tx_holding_fifo [64];
    logic [5:0] rx_wptr;
    logic [5:0] rx_rptr;
    logic [6:0] rx_count;
    logic [5:0] tx_wptr;
    logic [5:0] tx_rptr;
    logic [6:0] tx_count;
    logic rx_pop;
    logic tx_push;
    logic tx_pop;
    logic buf_ready;
    logic wr_fifo_ctrl;
    logic [6:0] rx_level;
    logic [6:0] tx_level;
    logic [1:0] tx_field;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ap_valid = hsel && htrans[1] && hready;

    // Address decode
    always_comb begin
        if (haddr[31:8] != 24'h000000 || hsize != 3'h2) begin
            next_sel = UAF_REG_NONE;
        end else if (haddr[7:0] == `UAF_OFS_FIFO_CONTROL) begin
            next_sel = UAF_REG_FIFO_CTRL;
        end else if (haddr[7:0] == `UAF_OFS_ENH_FEATURE) begin
            next_sel = UAF_REG_ENH;
        end else if (haddr[7:0] == `UAF_OFS_TX_HOLDING) begin
            next_sel = UAF_REG_TXH;
        end else if (haddr[7:0] == `UAF_OFS_RX_HOLDING) begin
            next_sel = UAF_REG_RXH;
        end else if (haddr[7:0] == `UAF_OFS_STATUS) begin
            next_sel = UAF_REG_STAT;
        end else begin
            next_sel = UAF_REG_NONE;
        end
    end

    // Data phase capture
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dp_sel <= UAF_REG_NONE;
            dp_write <= 1'b0;
        end else if (ce) begin
            dp_sel <= ap_valid ? next_sel : UAF_REG_NONE;
            dp_write <= ap_valid && hwrite;
        end
    end

    assign wr_fifo_ctrl = dp_write && dp_sel == UAF_REG_FIFO_CTRL;

    // Read data, registered at the address phase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (ce && ap_valid && !hwrite) begin
            if (next_sel == UAF_REG_RXH) begin
                hrdata <= {24'h000000, rx_holding_fifo[rx_rptr]};
            end else if (next_sel == UAF_REG_STAT) begin
                hrdata <= status;
            end else if (next_sel == UAF_REG_ENH) begin
                hrdata <= {27'h0000000, enhanced_functions_enable, 4'h0};
            end else begin
                hrdata <= 32'h00000000;
            end
        end
    end

    assign rx_pop = ce && ap_valid && !hwrite && next_sel == UAF_REG_RXH
        && rx_count != 7'h00;

    // Enhanced functions enable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enhanced_functions_enable <= 1'(`UAF_ENH_RESET >> `UAF_EFE_BIT);
        end else if (ce && dp_write && dp_sel == UAF_REG_ENH) begin
            enhanced_functions_enable <= hwdata[`UAF_EFE_BIT];
        end
    end

    // FIFO control fields
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fifo_control <= `UAF_FIFO_CTRL_RESET;
        end else if (ce) begin
            if (wr_fifo_ctrl) begin
                fifo_control.rx_trigger_level <= hwdata[7:6];
                if (enhanced_functions_enable) begin
                    fifo_control.tx_trigger_level <= hwdata[5:4];
                end
                fifo_control.dma_mode <= hwdata[3];
                fifo_control.fifo_enable <= hwdata[0];
            end
            // Reset bits stand one cycle, then clear themselves
            fifo_control.tx_fifo_reset <= wr_fifo_ctrl && hwdata[2];
            fifo_control.rx_fifo_reset <= wr_fifo_ctrl && hwdata[1];
        end
    end

    // Receive FIFO; the shifter never sees a reset from here
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_wptr <= 6'h00;
            rx_rptr <= 6'h00;
            rx_count <= 7'h00;
        end else if (ce) begin
            if (fifo_control.rx_fifo_reset) begin
                rx_wptr <= 6'h00;
                rx_rptr <= 6'h00;
                rx_count <= 7'h00;
            end else if (!fifo_control.fifo_enable) begin
                rx_wptr <= 6'h00;
                rx_rptr <= 6'h00;
                if (rx_char_valid) begin
                    rx_count <= 7'h01;
                end else if (rx_pop) begin
                    rx_count <= 7'h00;
                end
            end else begin
                if (rx_char_valid && rx_count != `UAF_DEPTH) begin
                    rx_wptr <= rx_wptr + 6'h01;
                end
                if (rx_pop) begin
                    rx_rptr <= rx_rptr + 6'h01;
                end
                rx_count <= rx_count
                    + {6'h00, rx_char_valid && rx_count != `UAF_DEPTH}
                    - {6'h00, rx_pop};
            end
        end
    end

    // Receive storage
    always_ff @(posedge clk_sys) begin
        if (ce && rx_char_valid && !fifo_control.rx_fifo_reset) begin
            if (!fifo_control.fifo_enable) begin
                rx_holding_fifo[0] <= rx_char_data;
            end else if (rx_count != `UAF_DEPTH) begin
                rx_holding_fifo[rx_wptr] <= rx_char_data;
            end
        end
    end

    // Transmit FIFO
    assign tx_push = dp_write && dp_sel == UAF_REG_TXH
        && tx_count != `UAF_DEPTH;
    assign tx_pop = buf_ready && tx_count != 7'h00;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_wptr <= 6'h00;
            tx_rptr <= 6'h00;
            tx_count <= 7'h00;
        end else if (ce) begin
            if (fifo_control.tx_fifo_reset) begin
                tx_wptr <= 6'h00;
                tx_rptr <= 6'h00;
                tx_count <= 7'h00;
            end else begin
                if (tx_push) begin
                    tx_wptr <= tx_wptr + 6'h01;
                end
                if (tx_pop) begin
                    tx_rptr <= tx_rptr + 6'h01;
                end
                tx_count <= tx_count + {6'h00, tx_push} - {6'h00, tx_pop};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (ce && tx_push && !fifo_control.tx_fifo_reset) begin
            tx_holding_fifo[tx_wptr] <= hwdata[7:0];
        end
    end

    // Two-entry buffer toward the transmit shifter
    uaf_out_buffer u_out_buffer (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .flush(fifo_control.tx_fifo_reset),
        .in_valid(tx_count != 7'h00 && !fifo_control.tx_fifo_reset),
        .in_data(tx_holding_fifo[tx_rptr]),
        .in_ready(buf_ready),
        .out_valid(tx_char_valid),
        .out_data(tx_char_data),
        .out_ready(tx_char_ready)
    );

    // Trigger levels
    assign tx_field = enhanced_functions_enable
        ? fifo_control.tx_trigger_level : 2'h0;
    always_comb begin
        case (fifo_control.rx_trigger_level)
            2'h0: rx_level = `UAF_RX_LVL0;
            2'h1: rx_level = `UAF_RX_LVL1;
            2'h2: rx_level = `UAF_RX_LVL2;
            default: rx_level = `UAF_RX_LVL3;
        endcase
        case (tx_field)
            2'h0: tx_level = `UAF_TX_LVL0;
            2'h1: tx_level = `UAF_TX_LVL1;
            2'h2: tx_level = `UAF_TX_LVL2;
            default: tx_level = `UAF_TX_LVL3;
        endcase
    end

    assign rx_trigger = fifo_control.fifo_enable && rx_count >= rx_level;
    assign tx_trigger = fifo_control.fifo_enable
        && (`UAF_DEPTH - tx_count) >= tx_level;
    assign dma_mode = fifo_control.dma_mode;

    always_comb begin
        status = '0;
        status.tx_trigger = tx_trigger;
        status.rx_trigger = rx_trigger;
        status.dma_mode = fifo_control.dma_mode;
        status.fifo_enable = fifo_control.fifo_enable;
        status.tx_count = tx_count;
        status.rx_count = rx_count;
    end

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    ctrl_read_zero_a: assert property (
        (ce && ap_valid && !hwrite && next_sel == UAF_REG_FIFO_CTRL)
        |=> hrdata == 32'h00000000)
        else $error("fifo control read returned nonzero");
    rx_level_high_a: assert property (
        (fifo_control.fifo_enable && fifo_control.rx_trigger_level == 2'h3
        && rx_count == 7'h3B) |-> !rx_trigger)
        else $error("rx trigger below 60 characters");
    tx_level_a: assert property (
        (fifo_control.fifo_enable && tx_field == 2'h2)
        |-> tx_trigger == (tx_count <= 7'h20))
        else $error("tx trigger wrong for 32 spaces");
    tx_field_lock_a: assert property (
        (ce && wr_fifo_ctrl && !enhanced_functions_enable)
        |=> $stable(fifo_control.tx_trigger_level))
        else $error("tx trigger field changed while locked");
    dma_mode_a: assert property (
        (ce && wr_fifo_ctrl) ##1 1'b1 |-> dma_mode == $past(hwdata[3]))
        else $error("dma mode not taken from write");
    tx_flush_a: assert property (
        (ce && wr_fifo_ctrl && hwdata[2]) ##1 ce |=> tx_count == 7'h00)
        else $error("tx fifo not emptied");
    rx_flush_a: assert property (
        (ce && wr_fifo_ctrl && hwdata[1]) ##1 ce |=> rx_count == 7'h00)
        else $error("rx fifo not emptied");
    reset_pulse_a: assert property (
        (ce && fifo_control.tx_fifo_reset && !wr_fifo_ctrl)
        |=> !fifo_control.tx_fifo_reset)
        else $error("tx fifo reset did not self clear");
    after_reset_a: assert property (
        $fell(rst) |-> !fifo_control.fifo_enable
        && !fifo_control.rx_fifo_reset && !fifo_control.tx_fifo_reset)
        else $error("fifo control not cleared by reset");
    depth_a: assert property (
        rx_count <= `UAF_DEPTH && tx_count <= `UAF_DEPTH)
        else $error("fifo count beyond 64");
    single_entry_a: assert property (
        (ce && !fifo_control.fifo_enable && !fifo_control.rx_fifo_reset
        && rx_char_valid) |=> rx_count == 7'h01)
        else $error("disabled rx fifo did not hold one entry");
endmodule : uaf_fifo_ctrl

`default_nettype wire

// ---- logic/uaf_out_buffer.sv ----
`timescale 1ns/1ps
`default_nettype none

module uaf_out_buffer (
    // Clock, reset, enable and flush
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic flush,
    // Filling side
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [7:0] out_data,
    input wire logic out_ready
);
    logic [7:0] entry [2];
    logic wr_idx;
    logic rd_idx;
    logic [1:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = entry[rd_idx];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Entry storage
    for (genvar i = 0; i < 2; i++) begin : g_entry
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                entry[i] <= 8'h00;
            end else if (ce && push && !flush && wr_idx == 1'(i)) begin
                entry[i] <= in_data;
            end
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk_sys) begin
        if (rst || (ce && flush)) begin
            wr_idx <= 1'b0;
            rd_idx <= 1'b0;
            count <= 2'h0;
        end else if (ce) begin
            if (push) begin
                wr_idx <= ~wr_idx;
            end
            if (pop) begin
                rd_idx <= ~rd_idx;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : uaf_out_buffer

`default_nettype wire

// ---- logic/uaf_pkg.sv ----
package uaf_pkg;

    typedef struct packed {
        logic [1:0] rx_trigger_level;
        logic [1:0] tx_trigger_level;
        logic dma_mode;
        logic tx_fifo_reset;
        logic rx_fifo_reset;
        logic fifo_enable;
    } uaf_fifo_control_t;

    typedef struct packed {
        logic [11:0] zero_hi;
        logic tx_trigger;
        logic rx_trigger;
        logic dma_mode;
        logic fifo_enable;
        logic zero_b15;
        logic [6:0] tx_count;
        logic zero_b7;
        logic [6:0] rx_count;
    } uaf_status_t;

    typedef enum logic [2:0] {
        UAF_REG_NONE,
        UAF_REG_FIFO_CTRL,
        UAF_REG_ENH,
        UAF_REG_TXH,
        UAF_REG_RXH,
        UAF_REG_STAT
    } uaf_reg_sel_t;

endpackage : uaf_pkg
